// [include/core_pm_defs.vh]
/*
  constants for the program memory access block of the core:
  widths, vectors, stack depth, pointer fields.
  assumes inclusion by bare name from the design files.
*/
`ifndef CORE_PM_DEFS_VH
`define CORE_PM_DEFS_VH

`define PC_W 15
`define PM_WORD_W 14
`define STACK_DEPTH 16
`define STACK_PTR_W 4
`define RESET_VECTOR 15'h0000
`define INT_VECTOR 15'h0004
`define PM_MASK_SMALL 15'h0fff
`define PM_MASK_LARGE 15'h1fff
`define PTR_W 16
`define PTR_PM_BIT 15
`define LIN_BASE 16'h2000
`define LIN_TOP 16'h29af
`define GPR_PER_BANK 7'h50
`define GPR_OFFSET 7'h20
`define INSN_COUNT 49
`define SHADOW_W 39

`endif

// [verilog/return_stack_mem.v]
/*
  return stack storage: 16 words of 15 bits, registered read data.
  assumes one clock; write and read addresses come from the caller.
*/
`timescale 1ns/10ps
`default_nettype none
`include "core_pm_defs.vh"

module return_stack_mem (
  input wire ref_clk,
  input wire wr_en,
  input wire [`STACK_PTR_W-1:0] wr_addr,
  input wire [`PC_W-1:0] wr_data,
  input wire [`STACK_PTR_W-1:0] rd_addr,
  output reg [`PC_W-1:0] rd_data
);
  reg [`PC_W-1:0] mem [0:`STACK_DEPTH-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [verilog/linear_map.v]
/*
  maps a linear general purpose ram address onto the banked
  12-bit data address: 80 bytes per bank starting at offset 20h.
  assumes the caller qualifies the address range.
*/
`timescale 1ns/10ps
`default_nettype none
`include "core_pm_defs.vh"

module linear_map (
  input wire [`PTR_W-1:0] lin_addr,
  output wire [11:0] data_addr
);
  wire [11:0] off;
  wire [4:0] bank;
  wire [6:0] idx;
  wire [11:0] bank_full;
  wire [11:0] idx_full;

  assign off = lin_addr[11:0];
  assign bank_full = off / 12'h050;
  assign bank = bank_full[4:0];
  assign idx_full = off - bank_full * 12'h050;
  assign idx = idx_full[6:0];
  assign data_addr = {bank, idx + `GPR_OFFSET};
endmodule
`default_nettype wire

// [verilog/core_program_memory_access.v]
/*
  program counter, return stack, interrupt shadows and two indirect
  pointers of an 8-bit core, with program memory reads through the
  pointers. assumes the execution core drives one request per cycle
  and honours fetch_stall; both memories answer within the address cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "core_pm_defs.vh"

// Notes on behaviour
// - a 16 entry by 15 bit return stack sits apart from data memory.
// - pushing past the top sets the overflow flag, popping empty sets underflow.
// - with stack reset enabled, either stack fault requests a device reset.
// - interrupt entry saves core registers to shadows, return restores them.
// - there are two 16-bit indirect pointers.
// - each pointer reaches all file registers and program memory.
// - a data port read aimed at program memory takes one extra cycle.
// - the program counter is 15 bits over a 32K by 14 space.
// - addresses beyond the implemented memory wrap inside it.
// - reset starts at 0000h and interrupts enter at 0004h.
// - implemented memory is 4096 or 8192 words per variant.
// - bit 7 of a pointer high byte sends data port reads to program memory.
// - a program word read into the working register keeps only its low 8 bits.
// - data port writes aimed at program memory are dropped.
// - a linear mode shows banked general ram as one contiguous block.
// - the decoder serves 49 instructions, including pointer ones.
module core_program_memory_access #(
  parameter LARGE_PM = 1
) (
  input wire ref_clk,
  input wire srst,
  input wire pc_inc,
  input wire pc_load,
  input wire [`PC_W-1:0] pc_load_value,
  input wire do_call,
  input wire do_return,
  input wire int_entry,
  input wire int_return,
  input wire stack_reset_en,
  input wire flag_clear,
  input wire [7:0] working_in,
  input wire [7:0] status_in,
  input wire [7:0] bank_in,
  input wire [6:0] pclath_in,
  input wire [7:0] ptr_sel_low_in,
  input wire ptr_write,
  input wire ptr_sel,
  input wire ptr_high,
  input wire [7:0] ptr_wdata,
  input wire port_read,
  input wire port_write,
  input wire port_sel,
  input wire [7:0] port_wdata,
  input wire [`PM_WORD_W-1:0] pm_rdata,
  input wire [7:0] dm_rdata,
  output reg [`PC_W-1:0] pc,
  output wire [`PC_W-1:0] pm_addr,
  output wire fetch_stall,
  output reg stack_over_flag,
  output reg stack_under_flag,
  output reg soft_reset_req,
  output reg [7:0] move_indirect_to_working,
  output reg move_valid,
  output reg [11:0] dm_addr,
  output reg dm_read,
  output reg dm_write,
  output reg [7:0] dm_wdata,
  output reg [15:0] indirect_pointer0,
  output reg [15:0] indirect_pointer1,
  output reg shadow_restore,
  output reg [`SHADOW_W-1:0] shadow_data,
  output wire [5:0] insn_count
);
  localparam ST_RUN = 1'b0;
  localparam ST_PMWAIT = 1'b1;

  reg state;
  reg [`STACK_PTR_W:0] depth;
  reg [`PC_W-1:0] pm_ptr_addr;
  reg [`PC_W-1:0] next_pc;
  wire [`PC_W-1:0] pc_mask;
  wire [`PC_W-1:0] stack_rd;
  wire [15:0] sel_ptr;
  wire [11:0] lin_addr;
  wire push;
  wire pop;
  wire pm_access;

  // variant size and wrap
  function [`PC_W-1:0] wrap;
    input [`PC_W-1:0] a;
    input [`PC_W-1:0] m;
    begin
      wrap = a & m;
    end
  endfunction

  function is_full;
    input [`STACK_PTR_W:0] d;
    begin
      is_full = (d == 5'd`STACK_DEPTH);
    end
  endfunction

  function is_empty;
    input [`STACK_PTR_W:0] d;
    begin
      is_empty = (d == 5'd0);
    end
  endfunction

  function in_linear;
    input [`PTR_W-1:0] p;
    begin
      in_linear = (p >= `LIN_BASE) && (p <= `LIN_TOP);
    end
  endfunction

  assign pc_mask = (LARGE_PM != 0) ? `PM_MASK_LARGE : `PM_MASK_SMALL;
  assign insn_count = 6'd`INSN_COUNT;

  assign push = do_call | int_entry;
  assign pop = do_return | int_return;
  return_stack_mem u_stack (
    .ref_clk(ref_clk),
    .wr_en(push && !is_full(depth)),
    .wr_addr(depth[`STACK_PTR_W-1:0]),
    .wr_data(pc),
    .rd_addr(depth[`STACK_PTR_W-1:0] - 4'd1),
    .rd_data(stack_rd)
  );

  assign sel_ptr = port_sel ? indirect_pointer1 : indirect_pointer0;
  assign pm_access = sel_ptr[`PTR_PM_BIT];
  linear_map u_lin (
    .lin_addr(sel_ptr),
    .data_addr(lin_addr)
  );

  assign fetch_stall = (state == ST_PMWAIT);
  assign pm_addr = (state == ST_PMWAIT) ? pm_ptr_addr : wrap(pc, pc_mask);

  always @* begin
    next_pc = pc;
    if (state == ST_PMWAIT) begin
      next_pc = pc;
    end else if (int_entry) begin
      next_pc = `INT_VECTOR;
    end else if (pc_load) begin
      next_pc = wrap(pc_load_value, pc_mask);
    end else if (pc_inc) begin
      next_pc = wrap(pc + 15'd1, pc_mask);
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pc <= `RESET_VECTOR;
    end else if (state == ST_PMWAIT) begin
      pc <= pc;
    end else if (pop && !is_empty(depth)) begin
      pc <= wrap(stack_rd, pc_mask);
    end else begin
      pc <= next_pc;
    end
  end

  // stack fault flags, set wins over clear
  always @(posedge ref_clk) begin
    if (srst) begin
      depth <= 5'd0;
      stack_over_flag <= 1'b0;
      stack_under_flag <= 1'b0;
      soft_reset_req <= 1'b0;
    end else begin
      soft_reset_req <= 1'b0;
      if (push && is_full(depth)) begin
        stack_over_flag <= 1'b1;
        soft_reset_req <= stack_reset_en;
      end else if (flag_clear) begin
        stack_over_flag <= 1'b0;
      end
      if (pop && is_empty(depth)) begin
        stack_under_flag <= 1'b1;
        soft_reset_req <= stack_reset_en;
      end else if (flag_clear) begin
        stack_under_flag <= 1'b0;
      end
      // push and pop together leave the depth alone
      if (push && !pop && !is_full(depth)) begin
        depth <= depth + 5'd1;
      end else if (pop && !push && !is_empty(depth)) begin
        depth <= depth - 5'd1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      shadow_restore <= 1'b0;
      shadow_data <= 39'h0;
    end else begin
      shadow_restore <= int_return;
      if (int_entry) begin
        shadow_data <= {working_in, status_in, bank_in, pclath_in, ptr_sel_low_in};
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      indirect_pointer0 <= 16'h0000;
      indirect_pointer1 <= 16'h0000;
    end else if (ptr_write) begin
      if (ptr_sel) begin
        if (ptr_high) begin
          indirect_pointer1[15:8] <= ptr_wdata;
        end else begin
          indirect_pointer1[7:0] <= ptr_wdata;
        end
      end else begin
        if (ptr_high) begin
          indirect_pointer0[15:8] <= ptr_wdata;
        end else begin
          indirect_pointer0[7:0] <= ptr_wdata;
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_RUN;
      pm_ptr_addr <= 15'h0000;
      move_indirect_to_working <= 8'h00;
      move_valid <= 1'b0;
      dm_addr <= 12'h000;
      dm_read <= 1'b0;
      dm_write <= 1'b0;
      dm_wdata <= 8'h00;
    end else begin
      move_valid <= 1'b0;
      dm_read <= 1'b0;
      dm_write <= 1'b0;
      case (state)
        ST_RUN: begin
          if (port_read && pm_access) begin
            pm_ptr_addr <= wrap(sel_ptr[`PC_W-1:0], pc_mask);
            state <= ST_PMWAIT;
          end else if (port_read || (port_write && !pm_access)) begin
            if (in_linear(sel_ptr)) begin
              dm_addr <= lin_addr;
            end else begin
              dm_addr <= sel_ptr[11:0];
            end
            dm_read <= port_read;
            dm_write <= port_write;
            dm_wdata <= port_wdata;
          end
          // program writes dropped by the guard above
          // data memory answers while dm_read stands
          if (dm_read) begin
            move_indirect_to_working <= dm_rdata;
            move_valid <= 1'b1;
          end
        end
        ST_PMWAIT: begin
          move_indirect_to_working <= pm_rdata[7:0];
          move_valid <= 1'b1;
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [bench/core_pm_props.sv]
/* assertions on the core_program_memory_access ports.
   assumes one clock and a synchronous active high srst. */
`timescale 1ns/10ps
`default_nettype none
`include "core_pm_defs.vh"
module core_pm_props #(
  parameter LARGE_PM = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic int_entry,
  input wire logic int_return,
  input wire logic flag_clear,
  input wire logic stack_reset_en,
  input wire logic port_read,
  input wire logic port_write,
  input wire logic port_sel,
  input wire logic [`PC_W-1:0] pc,
  input wire logic [`PC_W-1:0] pm_addr,
  input wire logic fetch_stall,
  input wire logic stack_over_flag,
  input wire logic soft_reset_req,
  input wire logic move_valid,
  input wire logic dm_write,
  input wire logic [15:0] indirect_pointer0,
  input wire logic [15:0] indirect_pointer1,
  input wire logic shadow_restore
);
  localparam [`PC_W-1:0] MASK = LARGE_PM ? `PM_MASK_LARGE : `PM_MASK_SMALL;
  wire pm_ptr = port_sel ? indirect_pointer1[15] : indirect_pointer0[15];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst_vec; $fell(srst) |-> pc == `RESET_VECTOR; endproperty
  property p_int_vec; int_entry && !fetch_stall |=> pc == `INT_VECTOR; endproperty
  property p_wrap; (pm_addr & ~MASK) == 15'h0000; endproperty
  property p_extra;
    port_read && !fetch_stall && pm_ptr |=> fetch_stall ##1 (move_valid && !fetch_stall);
  endproperty
  property p_stall_pc; fetch_stall |=> pc == $past(pc); endproperty
  property p_no_pm_wr; port_write && !fetch_stall && pm_ptr |=> !dm_write; endproperty
  property p_ovf_hold; stack_over_flag && !flag_clear |=> stack_over_flag; endproperty
  property p_sr_en; soft_reset_req |-> $past(stack_reset_en); endproperty
  property p_restore; int_return && !fetch_stall |=> shadow_restore; endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("pc off reset vector");
  a_int_vec: assert property (p_int_vec) else $error("pc off int vector");
  a_wrap: assert property (p_wrap) else $error("pm_addr beyond memory");
  a_extra: assert property (p_extra) else $error("no extra cycle");
  a_stall_pc: assert property (p_stall_pc) else $error("pc moved in stall");
  a_no_pm_wr: assert property (p_no_pm_wr) else $error("write reached memory");
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
  a_sr_en: assert property (p_sr_en) else $error("reset request disabled");
  a_restore: assert property (p_restore) else $error("no shadow restore");
  c_stall: cover property (port_read ##1 fetch_stall);
  c_ovf: cover property ($rose(stack_over_flag));
  c_int: cover property (int_entry ##1 pc == `INT_VECTOR);
endmodule
bind core_program_memory_access core_pm_props #(.LARGE_PM(LARGE_PM)) props_u (.ref_clk,
  .srst, .int_entry, .int_return, .flag_clear, .stack_reset_en, .port_read, .port_write,
  .port_sel, .pc, .pm_addr, .fetch_stall, .stack_over_flag, .soft_reset_req, .move_valid,
  .dm_write, .indirect_pointer0, .indirect_pointer1, .shadow_restore);
`default_nettype wire

// [bench/far_side_model.sv]
/* program flash and data memory answering in the cycle the address stands.
   assumes the core drives pm_addr every cycle. */
`timescale 1ns/10ps
`default_nettype none
`include "core_pm_defs.vh"
module far_side_model (
  input wire logic ref_clk,
  input wire logic [`PC_W-1:0] pm_addr,
  input wire logic dm_read,
  input wire logic [11:0] dm_addr,
  output var logic [`PM_WORD_W-1:0] pm_rdata,
  output var logic [7:0] dm_rdata
);
  logic [7:0] dm_last = 8'h00;
  assign pm_rdata = pm_addr[13:0] ^ 14'h2a5a;
  // an unread data bus shows the inverse of its last value
  assign dm_rdata = dm_read ? (dm_addr[7:0] ^ 8'h3c) : ~dm_last;
  always @(posedge ref_clk) begin
    if (dm_read) dm_last <= dm_addr[7:0] ^ 8'h3c;
  end
endmodule
`default_nettype wire

// [bench/tb_core_program_memory_access.sv]
/* bench for core_program_memory_access: pc, stack, shadows, pointers.
   assumes far_side_model stands for the flash and data memory. */
`timescale 1ns/10ps
`default_nettype none
`include "core_pm_defs.vh"
module tb_core_program_memory_access;
  localparam [9:0] INC = 1, LD = 2, CALL = 4, RET = 8, IENT = 16, IRET = 32;
  localparam [9:0] FCLR = 64, PWR = 128, RD = 256, WR = 512;
  logic ref_clk = 0, srst = 1, stack_reset_en = 0, ptr_sel = 0, ptr_high = 0, port_sel = 0;
  logic [9:0] pls = 0;
  logic [`PC_W-1:0] pc_load_value = 0, ret_pc;
  logic [7:0] working_in = 0, status_in = 0, bank_in = 0, ptr_sel_low_in = 0;
  logic [7:0] ptr_wdata = 0, port_wdata = 0;
  logic [6:0] pclath_in = 0;
  wire pc_inc, pc_load, do_call, do_return, int_entry, int_return, flag_clear;
  wire ptr_write, port_read, port_write, fetch_stall, stack_over_flag, stack_under_flag;
  wire soft_reset_req, move_valid, dm_read, dm_write, shadow_restore;
  wire [`PM_WORD_W-1:0] pm_rdata;
  wire [7:0] dm_rdata, move_indirect_to_working, dm_wdata;
  wire [`PC_W-1:0] pc, pm_addr;
  wire [`PC_W-1:0] pm_addr_small;
  wire [11:0] dm_addr;
  wire [15:0] indirect_pointer0, indirect_pointer1;
  wire [`SHADOW_W-1:0] shadow_data;
  wire [5:0] insn_count;
  int n_fail = 0, n_compared = 0, n_sr = 0, i;
  assign {port_write, port_read, ptr_write, flag_clear, int_return, int_entry, do_return,
    do_call, pc_load, pc_inc} = pls;
  core_program_memory_access #(.LARGE_PM(1)) dut_u (.*);
  far_side_model far_u (.*);
  core_program_memory_access #(.LARGE_PM(0)) dut_small_u (.*, .pc(), .pm_addr(pm_addr_small),
    .fetch_stall(), .stack_over_flag(), .stack_under_flag(), .soft_reset_req(),
    .move_indirect_to_working(), .move_valid(), .dm_addr(), .dm_read(), .dm_write(),
    .dm_wdata(), .indirect_pointer0(), .indirect_pointer1(), .shadow_restore(),
    .shadow_data(), .insn_count());
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (soft_reset_req) n_sr <= n_sr + 1;
  task chk(input logic [38:0] got, input logic [38:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task pulse(input logic [9:0] p);
    @(posedge ref_clk) pls <= p;
    @(posedge ref_clk) pls <= 0;
    #1;
  endtask
  task wptr(input logic s, input logic [15:0] v);
    ptr_sel <= s;
    ptr_high <= 1;
    ptr_wdata <= v[15:8];
    pulse(PWR);
    ptr_high <= 0;
    ptr_wdata <= v[7:0];
    pulse(PWR);
    chk(s ? indirect_pointer1 : indirect_pointer0, v);
  endtask
  task complete_run;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 0;
    #1;
    chk(pc, 15'h0000);
    chk(insn_count, 6'd49);
    pc_load_value <= 15'h3fff;
    pulse(LD);
    chk(pm_addr, 15'h1fff);
    chk(pm_addr_small, 15'h0fff);
    pulse(INC);
    chk(pm_addr, 15'h0000);
    chk(pm_addr_small, 15'h0000);
    $display("pc test done");
    stack_reset_en <= 1;
    for (i = 0; i < 17; i++) begin
      pc_load_value <= 15'(16 * i + 1);
      pulse(LD);
      pc_load_value <= 15'h0700;
      pulse(CALL);
    end
    repeat (3) @(posedge ref_clk);
    #1;
    chk(stack_over_flag, 1);
    chk(n_sr, 1);
    pulse(FCLR);
    chk(stack_over_flag, 0);
    stack_reset_en <= 0;
    for (i = 15; i >= 0; i--) begin
      pulse(RET);
      chk(pc, 15'(16 * i + 1));
    end
    ret_pc = pc;
    pulse(RET);
    chk(stack_under_flag, 1);
    chk(pc, ret_pc);
    repeat (3) @(posedge ref_clk);
    chk(n_sr, 1);
    pulse(FCLR);
    $display("stack test done");
    working_in <= 8'h5a;
    status_in <= 8'h03;
    bank_in <= 8'h1f;
    pclath_in <= 7'h22;
    ptr_sel_low_in <= 8'hc4;
    pulse(IENT);
    chk(pc, `INT_VECTOR);
    chk(shadow_data, {8'h5a, 8'h03, 8'h1f, 7'h22, 8'hc4});
    pulse(IRET);
    chk(shadow_restore, 1);
    $display("interrupt test done");
    wptr(0, 16'h8123);
    ret_pc = pc;
    pulse(RD);
    chk(fetch_stall, 1);
    chk(pm_addr, 15'h0123);
    @(posedge ref_clk);
    #1;
    chk(pc, ret_pc);
    chk(move_valid, 1);
    chk(move_indirect_to_working, 8'h79);
    chk(fetch_stall, 0);
    $display("program read test done");
    wptr(1, 16'h0045);
    port_sel <= 1;
    port_wdata <= 8'h96;
    pulse(WR);
    chk({dm_write, dm_addr, dm_wdata}, {1'b1, 12'h045, 8'h96});
    wptr(1, 16'h8045);
    pulse(WR);
    chk(dm_write, 0);
    port_sel <= 0;
    wptr(0, 16'h2000);
    pulse(RD);
    chk({dm_read, dm_addr}, {1'b1, 12'h020});
    @(posedge ref_clk);
    #1;
    chk({move_valid, move_indirect_to_working}, {1'b1, 8'h1c});
    wptr(0, 16'h2050);
    pulse(RD);
    chk(dm_addr, 12'h0a0);
    $display("data pointer test done");
    complete_run;
  end
endmodule
`default_nettype wire
